// *** pkg/sbcirq_pkg.sv ***
// Purpose: Shared constants and carriers for the interrupt collector
// Assumes: 25 MHz system clock standing in for the internal oscillator
// Notes:   Source index layout is local to this block
package sbcirq_pkg;

    localparam int unsigned CLK_HZ          = 25000000;
    // Times in their own units, as specified
    localparam int unsigned TIMEOUT_US      = 6000;
    localparam int unsigned MIN_PULSE_US    = 10;
    // Longest time rounds down, least time rounds up
    localparam int unsigned TIMEOUT_CYC     = (TIMEOUT_US * (CLK_HZ / 1000000));
    localparam int unsigned MIN_PULSE_CYC   =
        (MIN_PULSE_US * CLK_HZ + 999999) / 1000000;

    // Source counts
    localparam int unsigned NUM_WAKE        = 4;
    localparam int unsigned NUM_FAIL        = 3;
    localparam int unsigned NUM_STATE       = 6;

    // Wake flag positions
    localparam int unsigned CAN_WAKE_FLAG          = 0;
    localparam int unsigned WK_LIN          = 1;
    localparam int unsigned WK_PIN          = 2;
    localparam int unsigned WK_PERIODIC     = 3;
    // Chip failure flag positions
    localparam int unsigned FL_SPI          = 0;
    localparam int unsigned FL_RESET        = 1;
    localparam int unsigned FL_WATCHDOG     = 2;
    // Latched-state flag positions
    localparam int unsigned ST_OVERTEMP     = 0;
    localparam int unsigned ST_CAN_FAIL     = 1;
    localparam int unsigned ST_LIN_FAIL     = 2;
    localparam int unsigned ST_OVERCURRENT  = 3;
    localparam int unsigned ST_UV2          = 4;
    localparam int unsigned ST_UV3          = 5;

    // Read-only command and interrupt register addresses
    localparam logic [2:0] CMD_READ_ONLY    = 3'h7;
    localparam logic [2:0] ADDR_IRQ0        = 3'h0;
    localparam logic [2:0] ADDR_IRQ1        = 3'h1;
    localparam logic [2:0] ADDR_IRQ2        = 3'h2;

    // Operating modes
    typedef enum logic [2:0] {
        SBCIRQ_INIT    = 3'b000,
        SBCIRQ_NORMAL  = 3'b001,
        SBCIRQ_STOP    = 3'b010,
        SBCIRQ_SLEEP   = 3'b011,
        SBCIRQ_RESTART = 3'b100,
        SBCIRQ_FAILSAFE = 3'b101
    } sbcirq_mode_e;

    // Pin sequencer states
    typedef enum logic [1:0] {
        SBCIRQ_IDLE = 2'b00,
        SBCIRQ_LOW  = 2'b01,
        SBCIRQ_GAP  = 2'b10
    } sbcirq_pin_e;

    // Read access from the serial decoder
    typedef struct packed {
        logic       strobe;
        logic [2:0] cmd;
        logic [2:0] addr;
    } sbcirq_rd_s;

    // Status read-back
    typedef struct packed {
        logic [NUM_WAKE-1:0]  wake;
        logic                 summary;
        logic [NUM_FAIL-1:0]  fail;
        logic [NUM_STATE-1:0] state;
    } sbcirq_stat_s;

endpackage

// *** src/sbcirq_collector.sv ***
// Purpose: Interrupt collector driving an open-drain interrupt pin
// Assumes: Event inputs are one-cycle pulses, conditions are levels
// Notes:   Pin enable low means the pin is pulled low by this block
// Operation
// RULE1 - Unmasked event pulls interrupt pin low
// RULE2 - Mask blocks pin, status still set
// RULE3 - Regulator undervoltage interrupts on both edges
// RULE4 - State bits latch failure until read
// RULE5 - Failure and wake flags clear on read
// RULE6 - Read-only of register zero releases pin
// RULE7 - Host reads zero, then one and two
// RULE8 - Summary bit set while any other bit; code ORs only failure and state bits, wake bits excluded
// RULE9 - Many events before read, one pulse
// RULE10 - Pin low at most the time-out
// RULE11 - Gap of time-out; pending event deferred
// RULE12 - Low pulse lasts at least minimum width
// RULE13 - Pin signalling only in normal, stop
// RULE14 - All masks enabled at reset, restart
// RULE15 - Switch-on sets undervoltage bit, raises interrupt
// RULE16 - Early read keeps bit; recovery re-interrupts
// RULE17 - No undervoltage interrupt while regulator off
// RULE18 - Regulator overtemp triggers on rising edge
// RULE19 - Deferred pulse kept though bits cleared
// RULE20 - Pin sampled as configuration in init
// RULE21 - Timer limits are design parameters
module sbcirq_collector
    import sbcirq_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC, // see RULE21
    parameter int unsigned PULSE_CYCLES   = MIN_PULSE_CYC
)(
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // Operating mode
    input  wire sbcirq_mode_e         mode,
    input  wire logic                 reset_out_n,
    // Event pulses
    input  wire logic [NUM_WAKE-1:0]  wake_evt,
    input  wire logic [NUM_FAIL-1:0]  fail_evt,
    // Live failure conditions
    input  wire logic [NUM_STATE-1:0] state_cond,
    // Regulator control
    input  wire logic                 reg2_on,
    input  wire logic                 reg3_on,
    input  wire logic                 reg2_switch_on,
    input  wire logic                 reg3_switch_on,
    // Masks, 1 enables a source
    input  wire logic                 mask_wr,
    input  wire logic [NUM_WAKE-1:0]  mask_wake_in,
    input  wire logic [NUM_FAIL-1:0]  mask_fail_in,
    input  wire logic [NUM_STATE-1:0] mask_state_in,
    // Serial read access
    input  wire sbcirq_rd_s           rd,
    // Status read-back
    output sbcirq_stat_s              stat,
    output logic                      can_wake_flag,
    output logic                      lin_wake_flag,
    output logic                      periodic_wake_flag,
    output logic                      bad_watchdog_cfg_flag,
    output logic                      overtemp_flag,
    output logic                      second_reg_undervolt_flag,
    output logic                      third_reg_undervolt_flag,
    // Configuration strap
    output logic                      cfg_sel_24,
    // Interrupt pin
    input  wire logic                 irq_pin_in,
    output logic                      irq_pin_out,
    output logic                      irq_pin_oe_n
);

    localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [CW-1:0] TO_LIM = CW'(TIMEOUT_CYCLES - 1);
    localparam logic [CW-1:0] PW_LIM = CW'(PULSE_CYCLES - 1);

    logic                 rst_meta;
    logic                 rst_sync_n;
    logic [NUM_WAKE-1:0]  wake_q;
    logic [NUM_FAIL-1:0]  fail_q;
    logic [NUM_STATE-1:0] state_q;
    logic [NUM_WAKE-1:0]  mask_wake;
    logic [NUM_FAIL-1:0]  mask_fail;
    logic [NUM_STATE-1:0] mask_state;
    logic [NUM_STATE-1:0] cond_d;
    logic [NUM_STATE-1:0] state_trig;
    logic [NUM_STATE-1:0] state_live;
    logic                 rd_irq0;
    logic                 rd_irq12;
    logic                 trig;
    logic                 pending;
    logic                 op_mode;
    sbcirq_pin_e          pin_st;
    logic [CW-1:0]        cnt;
    logic                 read_seen;

    // Read-only access decode
    function automatic logic is_read(input sbcirq_rd_s r,
                                     input logic [2:0] a);
        return r.strobe && (r.cmd == CMD_READ_ONLY) && (r.addr == a);
    endfunction

    // Reset release
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign rd_irq0  = is_read(rd, ADDR_IRQ0);
    assign rd_irq12 = is_read(rd, ADDR_IRQ1) || is_read(rd, ADDR_IRQ2);
    assign op_mode  = (mode == SBCIRQ_NORMAL) || (mode == SBCIRQ_STOP);

    // Live conditions, undervoltage ones gated by regulator enable
    always_comb
    begin
        state_live = state_cond;
        state_live[ST_UV2] = state_cond[ST_UV2] && reg2_on; // see RULE17
        state_live[ST_UV3] = state_cond[ST_UV3] && reg3_on; // see RULE17
    end

    // Edge triggers per state source
    always_comb
    begin
        state_trig = state_live & ~cond_d; // see RULE18
        state_trig[ST_UV2] = (state_live[ST_UV2] ^ cond_d[ST_UV2])
                             && reg2_on; // see RULE3
        state_trig[ST_UV3] = (state_live[ST_UV3] ^ cond_d[ST_UV3])
                             && reg3_on; // see RULE3
        state_trig[ST_UV2] |= reg2_switch_on; // see RULE15
        state_trig[ST_UV3] |= reg3_switch_on; // see RULE15
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            cond_d <= '0;
        else
            cond_d <= state_live;
    end

    // Masks, all enabled after reset and restart
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            mask_wake  <= '1; // see RULE14
            mask_fail  <= '1;
            mask_state <= '1;
        end
        else if (mode == SBCIRQ_RESTART)
        begin
            mask_wake  <= '1; // see RULE14
            mask_fail  <= '1;
            mask_state <= '1;
        end
        else if (mask_wr)
        begin
            mask_wake  <= mask_wake_in;
            mask_fail  <= mask_fail_in;
            mask_state <= mask_state_in;
        end
    end

    // Event flags, set wins over read clear
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            wake_q <= '0;
            fail_q <= '0;
        end
        else
        begin
            wake_q <= (rd_irq0 ? '0 : wake_q) | wake_evt; // see RULE5
            fail_q <= (rd_irq12 ? '0 : fail_q) | fail_evt; // see RULE5
        end
    end

    // State flags latch, then follow the live condition after read
    generate
        for (genvar i = 0; i < NUM_STATE; i++)
        begin : g_state
            always_ff @(posedge clk_sys or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                    state_q[i] <= 1'b0;
                else if (state_trig[i] && (state_live[i] ||
                         i == ST_UV2 || i == ST_UV3) &&
                         !(cond_d[i] && !state_live[i]))
                    state_q[i] <= 1'b1; // see RULE4
                else if (rd_irq12)
                    state_q[i] <= state_live[i]; // see RULE16
            end
        end
    endgenerate

    assign trig = op_mode && (|(wake_evt & mask_wake) |
                  |(fail_evt & mask_fail) |
                  |(state_trig & mask_state)); // see RULE2

    // Pin sequencer: low, then gap; events merge into one pending
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pin_st    <= SBCIRQ_IDLE;
            cnt       <= '0;
            pending   <= 1'b0;
            read_seen <= 1'b0;
        end
        else if (!op_mode)
        begin
            pin_st    <= SBCIRQ_IDLE; // see RULE13
            cnt       <= '0;
            pending   <= 1'b0;
            read_seen <= 1'b0;
        end
        else
        begin
            case (pin_st)
                SBCIRQ_IDLE:
                begin
                    cnt       <= '0;
                    read_seen <= 1'b0;
                    if (trig || pending)
                    begin
                        pin_st  <= SBCIRQ_LOW; // see RULE1
                        pending <= 1'b0;
                    end
                end
                SBCIRQ_LOW: // see RULE9
                begin
                    cnt       <= cnt + CW'(1);
                    read_seen <= read_seen || rd_irq0;
                    if (((read_seen || rd_irq0) && cnt >= PW_LIM)
                        || cnt == TO_LIM) // see RULE6 RULE10 RULE12
                    begin
                        pin_st <= SBCIRQ_GAP;
                        cnt    <= '0;
                    end
                end
                SBCIRQ_GAP:
                begin
                    cnt <= cnt + CW'(1);
                    if (trig)
                        pending <= 1'b1; // see RULE11 RULE19
                    if (cnt == TO_LIM)
                    begin
                        pin_st <= SBCIRQ_IDLE;
                        cnt    <= '0;
                    end
                end
                default:
                    pin_st <= SBCIRQ_IDLE;
            endcase
        end
    end

    // Pin drive and configuration strap
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            irq_pin_oe_n <= 1'b1;
            irq_pin_out  <= 1'b0;
            cfg_sel_24   <= 1'b0;
        end
        else
        begin
            irq_pin_oe_n <= !(op_mode && pin_st == SBCIRQ_LOW); // see RULE1
            irq_pin_out  <= 1'b0;
            if (mode == SBCIRQ_INIT && !reset_out_n)
                cfg_sel_24 <= irq_pin_in; // see RULE20
        end
    end

    // Status outputs
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            stat                      <= '0;
            can_wake_flag             <= 1'b0;
            lin_wake_flag             <= 1'b0;
            periodic_wake_flag        <= 1'b0;
            bad_watchdog_cfg_flag     <= 1'b0;
            overtemp_flag             <= 1'b0;
            second_reg_undervolt_flag <= 1'b0;
            third_reg_undervolt_flag  <= 1'b0;
        end
        else
        begin
            stat.wake    <= wake_q;
            stat.summary <= |fail_q || |state_q; // see RULE8
            stat.fail    <= fail_q;
            stat.state   <= state_q;
            can_wake_flag             <= wake_q[CAN_WAKE_FLAG];
            lin_wake_flag             <= wake_q[WK_LIN];
            periodic_wake_flag        <= wake_q[WK_PERIODIC];
            bad_watchdog_cfg_flag     <= fail_q[FL_WATCHDOG];
            overtemp_flag             <= state_q[ST_OVERTEMP];
            second_reg_undervolt_flag <= state_q[ST_UV2];
            third_reg_undervolt_flag  <= state_q[ST_UV3];
        end
    end

    // Checks
    sequence s_low_start;
        pin_st == SBCIRQ_IDLE && op_mode && (trig || pending);
    endsequence

    AST_PIN_DROPS: assert property (@(posedge clk_sys) // see RULE1
        disable iff (!rst_sync_n)
        s_low_start |=> pin_st == SBCIRQ_LOW ##1 !irq_pin_oe_n)
        else $error("pin not driven low after event");

    AST_MASKED_QUIET: assert property (@(posedge clk_sys) // see RULE2
        disable iff (!rst_sync_n)
        pin_st == SBCIRQ_IDLE && !pending && !trig && op_mode
        |=> pin_st == SBCIRQ_IDLE)
        else $error("pin moved without unmasked source");

    AST_WAKE_CLEAR: assert property (@(posedge clk_sys) // see RULE5
        disable iff (!rst_sync_n)
        rd_irq0 && !wake_evt[CAN_WAKE_FLAG] |=> !wake_q[CAN_WAKE_FLAG])
        else $error("wake flag not cleared on read");

    AST_SET_WINS: assert property (@(posedge clk_sys) // see RULE5
        disable iff (!rst_sync_n)
        fail_evt[FL_SPI] |=> fail_q[FL_SPI])
        else $error("failure event lost");

    AST_SUMMARY: assert property (@(posedge clk_sys) // see RULE8
        disable iff (!rst_sync_n)
        ##1 stat.summary == $past(|fail_q || |state_q))
        else $error("summary bit mismatch");

    AST_MIN_PULSE: assert property (@(posedge clk_sys) // see RULE12
        disable iff (!rst_sync_n)
        op_mode && pin_st == SBCIRQ_LOW && cnt < PW_LIM && op_mode
        |=> pin_st == SBCIRQ_LOW || !op_mode)
        else $error("pulse shorter than minimum");

    AST_TIMEOUT: assert property (@(posedge clk_sys) // see RULE10
        disable iff (!rst_sync_n)
        pin_st == SBCIRQ_LOW && cnt == TO_LIM |=> pin_st != SBCIRQ_LOW)
        else $error("pin low beyond time-out");

    AST_GAP_HOLD: assert property (@(posedge clk_sys) // see RULE11
        disable iff (!rst_sync_n)
        pin_st == SBCIRQ_GAP && cnt != TO_LIM && op_mode
        |=> pin_st == SBCIRQ_GAP)
        else $error("gap ended before time-out");

    AST_DEFER: assert property (@(posedge clk_sys) // see RULE19
        disable iff (!rst_sync_n)
        pin_st == SBCIRQ_GAP && trig && op_mode |=> pending || !op_mode)
        else $error("event in gap not stored");

    AST_OFF_MODE: assert property (@(posedge clk_sys) // see RULE13
        disable iff (!rst_sync_n)
        !op_mode |=> ##1 irq_pin_oe_n)
        else $error("pin driven outside normal or stop");

    AST_RESTART_MASK: assert property (@(posedge clk_sys) // see RULE14
        disable iff (!rst_sync_n)
        mode == SBCIRQ_RESTART |=> &mask_wake && &mask_state)
        else $error("masks not enabled after restart");

endmodule

// *** tb/sbcirq_mcu_model.sv ***
// Purpose: Microcontroller side reading interrupt status after the pin
// Assumes: Pin level already resolved by the bench, pull-up when released
// Notes:   Requests change on the falling edge, one-cycle strobes
module sbcirq_mcu_model
    import sbcirq_pkg::*;
(
    // Clock and pin
    input  wire logic         clk_sys,
    input  wire logic         irq_level,
    // Behaviour control
    input  wire logic         auto_en,
    input  wire logic [7:0]   delay,
    // Status and requests
    input  wire sbcirq_stat_s stat,
    output sbcirq_rd_s        rd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial rd = '0;

    task automatic read_reg(input logic [2:0] a);
        rd <= '{1'b1, CMD_READ_ONLY, a};
        @(negedge clk_sys);
        rd <= '0;
        repeat (2) @(negedge clk_sys);
    endtask

    // Wake register first, others only when summary is set
    always
    begin
        @(negedge clk_sys);
        if (auto_en && !irq_level)
        begin
            repeat (delay) @(negedge clk_sys);
            read_reg(ADDR_IRQ0);
            if (stat.summary)
            begin
                read_reg(ADDR_IRQ1);
                read_reg(ADDR_IRQ2);
            end
            for (int i = 0; i < 400 && !irq_level; i++)
                @(negedge clk_sys);
        end
    end
endmodule

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the interrupt collector
// Assumes: Short timer parameters, pin pulled up outside init
// Notes:   Monitor measures every low pulse and every gap
module testbench
    import sbcirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TO_C = 200;
    localparam int PW_C = 4;

    logic                 clk_sys     = 1'b0;
    logic                 rst_n       = 1'b0;
    sbcirq_mode_e         mode        = SBCIRQ_INIT;
    logic                 reset_out_n = 1'b0;
    logic [3:0]           w           = 4'h0;
    logic [2:0]           f           = 3'h0;
    logic [NUM_STATE-1:0] state_cond  = '0;
    logic [1:0]           reg_on      = 2'h0;
    logic [1:0]           sw_on       = 2'h0;
    logic                 mask_wr     = 1'b0;
    logic [12:0]          mask_all    = 13'h0;
    logic                 strap       = 1'b0;
    logic                 in_init     = 1'b1;
    logic                 auto_en     = 1'b0;
    logic [7:0]           delay       = 8'h0;
    logic [7:0]           rnd         = 8'h12;
    sbcirq_rd_s           tb_rd       = '0;
    sbcirq_rd_s           mcu_rd;
    sbcirq_stat_s         stat;
    logic [2:0]           nf;
    logic [3:0]           wf;
    logic                 pin_out;
    logic                 cfg_sel_24;
    logic                 irq_pin_oe_n;
    logic                 irq_level;
    int                   errors      = 0;
    int                   compares    = 0;
    int                   falls       = 0;
    int                   low_len     = 0;
    int                   high_len    = 0;
    int                   last_low    = 0;
    int                   cyc         = 0;
    int                   f0;

    assign irq_level = !irq_pin_oe_n ? 1'b0 : (in_init ? strap : 1'b1);

    always #20 clk_sys = ~clk_sys;

    sbcirq_collector #(.TIMEOUT_CYCLES(TO_C), .PULSE_CYCLES(PW_C)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .mode(mode),
        .reset_out_n(reset_out_n), .wake_evt(w), .fail_evt(f),
        .state_cond(state_cond), .reg2_on(reg_on[0]), .reg3_on(reg_on[1]),
        .reg2_switch_on(sw_on[0]), .reg3_switch_on(sw_on[1]),
        .mask_wr(mask_wr), .mask_wake_in(mask_all[12:9]),
        .mask_fail_in(mask_all[8:6]), .mask_state_in(mask_all[5:0]),
        .rd(mcu_rd.strobe ? mcu_rd : tb_rd), .stat(stat),
        .can_wake_flag(wf[0]), .lin_wake_flag(wf[1]),
        .periodic_wake_flag(wf[2]),
        .bad_watchdog_cfg_flag(wf[3]), .overtemp_flag(nf[0]),
        .second_reg_undervolt_flag(nf[1]),
        .third_reg_undervolt_flag(nf[2]), .cfg_sel_24(cfg_sel_24),
        .irq_pin_in(irq_level), .irq_pin_out(pin_out),
        .irq_pin_oe_n(irq_pin_oe_n));

    sbcirq_mcu_model u_mcu (.clk_sys(clk_sys), .irq_level(irq_level),
        .auto_en(auto_en), .delay(delay), .stat(stat), .rd(mcu_rd));

    task automatic close_out();
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_bits(input string n, input logic [15:0] e,
                            input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_range(input string n, input int lo, input int hi,
                             input int g);
        compares++;
        if (g < lo || g > hi)
        begin
            errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic fire(input logic [3:0] wv, input logic [2:0] fv);
        w = wv;
        f = fv;
        tick(1);
        w = 4'h0;
        f = 3'h0;
    endtask

    task automatic rd_reg(input logic [2:0] a);
        tb_rd = '{1'b1, CMD_READ_ONLY, a};
        tick(1);
        tb_rd = '0;
        tick(1);
    endtask

    task automatic rd_all();
        rd_reg(ADDR_IRQ0);
        rd_reg(ADDR_IRQ1);
        rd_reg(ADDR_IRQ2);
        tick(3);
    endtask

    task automatic wait_pin(input logic lvl, input int n);
        for (int i = 0; i < n && irq_level !== lvl; i++)
            tick(1);
        chk_bits("irq_pin", 16'(lvl), 16'(irq_level));
    endtask

    task automatic settle();
        wait_pin(1'b1, TO_C + 20);
        tick(TO_C + 4);
    endtask

    task automatic no_pulse(input int n);
        f0 = falls;
        tick(n);
        chk_range("irq_falls", f0, f0, falls);
    endtask

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // Pulse and gap model of the pin
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            errors++;
            close_out();
        end
        if (in_init)
            high_len = 0;
        else if (!irq_level)
        begin
            if (low_len == 0 && falls > 0)
                chk_range("irq_gap", TO_C, 1 << 30, high_len);
            if (low_len == 0)
                falls++;
            low_len++;
        end
        else
        begin
            if (low_len > 0)
            begin
                chk_range("irq_low", PW_C, TO_C + 2,
                          low_len);
                last_low = low_len;
                high_len = 0;
            end
            low_len = 0;
            high_len++;
        end
    end

    initial
    begin
        tick(2);
        rst_n = 1'b1;
        tick(3);
        for (int s = 0; s < 2; s++)
        begin
            strap = s[0];
            tick(4);
            chk_bits("cfg_sel_24", 16'(strap), 16'(cfg_sel_24));
        end
        fire(4'h1, 3'h0);
        for (int c = 0; c < 10; c++)
        begin
            tick(1);
            chk_bits("irq_oe_n", 16'h1, 16'(irq_pin_oe_n));
        end
        reset_out_n = 1'b1;
        in_init = 1'b0;
        mode = SBCIRQ_NORMAL;
        rd_all();
        chk_bits("stat", 16'h0, 16'(stat));
        for (int i = 0; i < 7; i++)
        begin
            mode = i[0] ? SBCIRQ_STOP : SBCIRQ_NORMAL;
            rnd = lfsr(rnd);
            delay = (i == 0) ? 8'h0 : {5'h0, rnd[2:0]};
            fire((i < 4) ? 4'(1 << i) : 4'h0,
                 (i < 4) ? 3'h0 : 3'(1 << (i - 4)));
            wait_pin(1'b0, 4);
            chk_bits("stat_flags",
                     (i < 4) ? 16'(1 << (i + 4)) : 16'(8 | 1 << (i - 4)),
                     16'({stat.wake, stat.summary, stat.fail}));
            chk_bits("named_flags", 16'({i == 6, i == 3, i == 1, i == 0}),
                     16'(wf));
            chk_bits("irq_pin_out", 16'h0, 16'(pin_out));
            auto_en = 1'b1;
            wait_pin(1'b1, PW_C + 40);
            tick(3);
            chk_bits("stat", 16'h0, 16'(stat));
            auto_en = 1'b0;
            settle();
        end
        mask_wr = 1'b1;
        tick(1);
        mask_wr = 1'b0;
        fire(4'h2, 3'h1);
        no_pulse(20);
        chk_bits("stat_flags", 16'h29,
                 16'({stat.wake, stat.summary, stat.fail}));
        rd_all();
        mode = SBCIRQ_RESTART;
        tick(3);
        mode = SBCIRQ_NORMAL;
        tick(3);
        fire(4'h2, 3'h0);
        wait_pin(1'b0, 4);
        rd_reg(ADDR_IRQ0);
        wait_pin(1'b1, PW_C + 20);
        settle();
        fire(4'h4, 3'h0);
        wait_pin(1'b0, 4);
        wait_pin(1'b1, TO_C + 10);
        // Monitor records the pulse at the next rising edge
        tick(1);
        chk_range("irq_low_max", TO_C - 2, TO_C + 2, last_low);
        chk_bits("stat_wake", 16'h4, 16'(stat.wake));
        tick(10);
        fire(4'h8, 3'h0);
        no_pulse(20);
        rd_reg(ADDR_IRQ0);
        tick(3);
        chk_bits("stat_wake", 16'h0, 16'(stat.wake));
        wait_pin(1'b0, TO_C);
        rd_reg(ADDR_IRQ0);
        wait_pin(1'b1, PW_C + 20);
        settle();
        f0 = falls;
        fire(4'h1, 3'h0);
        tick(3);
        fire(4'h0, 3'h2);
        tick(3);
        chk_bits("stat_flags", 16'h1a,
                 16'({stat.wake, stat.summary, stat.fail}));
        rd_all();
        settle();
        chk_range("irq_falls", f0 + 1, f0 + 1, falls);
        auto_en = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            f0 = falls;
            reg_on[k] = 1'b1;
            state_cond[ST_UV2 + k] = 1'b1;
            sw_on[k] = 1'b1;
            tick(1);
            sw_on[k] = 1'b0;
            wait_pin(1'b0, 4);
            wait_pin(1'b1, PW_C + 40);
            tick(3);
            chk_bits("uv_flag", 16'h1, 16'(nf[1 + k]));
            settle();
            state_cond[ST_UV2 + k] = 1'b0;
            wait_pin(1'b0, 4);
            wait_pin(1'b1, PW_C + 40);
            tick(3);
            chk_bits("uv_flag", 16'h0, 16'(stat.state[ST_UV2 + k]));
            settle();
            chk_range("irq_falls", f0 + 2, f0 + 2, falls);
            reg_on[k] = 1'b0;
            state_cond[ST_UV2 + k] = 1'b1;
            no_pulse(20);
            state_cond[ST_UV2 + k] = 1'b0;
            no_pulse(20);
        end
        state_cond[ST_OVERTEMP] = 1'b1;
        wait_pin(1'b0, 4);
        wait_pin(1'b1, PW_C + 40);
        tick(3);
        chk_bits("ot_flag", 16'h1, 16'(nf[0]));
        settle();
        state_cond[ST_OVERTEMP] = 1'b0;
        no_pulse(20);
        rd_all();
        chk_bits("ot_flag", 16'h0, 16'(stat.state[ST_OVERTEMP]));
        close_out();
    end
endmodule
